// ---- hdl/ecl_pkg.sv ----
// Constants shared by both ends of the external control latch bank.
// Assumes one 10 MHz core clock and octal I/O device addresses.
package ecl_pkg;

  // Number of latches and width of the line field.
  localparam int unsigned LINE_COUNT = 8;
  localparam int unsigned LINE_W     = 3;
  // Device address field width, octal 00 to 77.
  localparam int unsigned ADDR_W     = 6;
  // Output data width of the I/O bus.
  localparam int unsigned DATA_W     = 16;

  // Converter module address, octal 50 (range 50 to 57).
  localparam logic [5:0] DEV_ADDR       = 6'h28;
  // Block transfer controller address pair, octal 20 and 21.
  localparam logic [5:0] BIC_ADDR_START = 6'h10;
  localparam logic [5:0] BIC_ADDR_END   = 6'h11;
  // Lowest and highest legal controller address, octal 20 and 27.
  localparam logic [5:0] BIC_ADDR_MIN   = 6'h10;
  localparam logic [5:0] BIC_ADDR_MAX   = 6'h17;

  // Line codes with a fixed meaning toward the controller.
  localparam logic [2:0] LINE_BIC_OUT   = 3'h0;
  localparam logic [2:0] LINE_BIC_IN    = 3'h1;

  // Latch values after reset.
  localparam logic [7:0] LATCH_RESET    = 8'h00;

  // Timing: core clock period and the set command pulse length.
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SET_PULSE_NS  = 200;
  localparam int unsigned SET_PULSE_CYCLES =
    (SET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SET_PULSE_LAST =
    2'(SET_PULSE_CYCLES - 1);

endpackage

// ---- hdl/ecl_io_if.sv ----
// Host I/O bus between the computer end and the latch bank.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/100ps
`default_nettype none
interface ecl_io_if;
  import ecl_pkg::*;
  // Set command strobe, held for the set pulse length.
  logic                ext_control_set_cmd;
  logic [LINE_W-1:0]   cmd_line;    // Line field of the command.
  logic [ADDR_W-1:0]   cmd_addr;    // Device address of the command.
  // Word output strobe toward any device, one cycle.
  logic                dout_stb;
  logic [ADDR_W-1:0]   dout_addr;   // Device address of the word.
  logic [DATA_W-1:0]   dout_data;   // Data word.
  // Latch outputs as seen by the host side wiring.
  logic [7:0]          ext_control_out;

  modport host (
    output ext_control_set_cmd,
    output cmd_line,
    output cmd_addr,
    output dout_stb,
    output dout_addr,
    output dout_data,
    input  ext_control_out
  );

  modport dev (
    input  ext_control_set_cmd,
    input  cmd_line,
    input  cmd_addr,
    output ext_control_out
  );
endinterface
`default_nettype wire

// ---- hdl/ecl_latch_bank.sv ----
// Device end: eight external control latches at one converter address.
// Assumes set commands arrive synchronous to core_clk over the I/O bus
// and that latch reset inputs come from external wiring, active low.
`timescale 1ns/100ps
`default_nettype none
module ecl_latch_bank
  import ecl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  ecl_io_if.dev            io,
  input  wire logic [7:0]  ext_control_reset_in_n,
  output logic      [7:0]  backplane_out,
  output logic             bic_out_connect,
  output logic             bic_in_select,
  output logic      [7:0]  set_pulse
);

  // Decoded command: one bit per line, high while the set strobe
  // addresses this module and that line.
  logic [7:0] set_hit;

  // Next and current latch state.
  logic [7:0] latch_d;
  logic [7:0] latch_q;

  // Registered copies for the backplane and controller taps.
  logic [7:0] bp_q;
  logic       bic_out_q;
  logic       bic_in_q;

  // Registered record of a set strobe arriving, per line.
  logic [7:0] set_pulse_q;

  // Address decode. Only one device address answers; commands to
  // the controller pair or other modules leave the bank untouched.
  always_comb
  begin
    set_hit = 8'h00;
    if (io.ext_control_set_cmd && (io.cmd_addr == DEV_ADDR))
    begin
      set_hit[io.cmd_line] = 1'b1;
    end
  end

  // One latch cell per line. The set term dominates the reset term
  // so a command that meets a held reset still shows for its length,
  // which is what the grounded-reset pulse wiring relies on.
  genvar gi;
  generate
    for (gi = 0; gi < LINE_COUNT; gi++)
    begin : g_cell
      always_comb
      begin
        if (set_hit[gi])
        begin
          latch_d[gi] = 1'b1;
        end
        else if (!ext_control_reset_in_n[gi])
        begin
          latch_d[gi] = 1'b0;
        end
        else
        begin
          // Commands to other lines never disturb this cell.
          latch_d[gi] = latch_q[gi];
        end
      end
    end
  endgenerate

  // Latch register. Software has no path that writes a zero here;
  // only the power-on reset and the reset inputs clear a latch.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      latch_q <= LATCH_RESET;
    end
    else
    begin
      latch_q <= latch_d;
    end
  end

  // Output taps. Each is its own flop fed from the same next value so
  // every tap changes on the same edge as the latch itself; chained
  // wiring (one output into another reset) then clears the next latch
  // one edge after the first is set.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      bp_q      <= LATCH_RESET;
      bic_out_q <= 1'b0;
      bic_in_q  <= 1'b0;
    end
    else
    begin
      bp_q      <= latch_d;
      bic_out_q <= latch_d[LINE_BIC_OUT];
      bic_in_q  <= latch_d[LINE_BIC_IN];
    end
  end

  // Set strobe record, useful to wiring that wants the raw command
  // rather than the latched level.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      set_pulse_q <= 8'h00;
    end
    else
    begin
      set_pulse_q <= set_hit;
    end
  end

  // Drive ports. The interface copy feeds the host side and any
  // external chaining; chained clearing is purely wiring from
  // these outputs into ext_control_reset_in_n of another line.
  // chain source outputs
  assign io.ext_control_out = latch_q;
  assign backplane_out      = bp_q;
  assign bic_out_connect    = bic_out_q;
  assign bic_in_select      = bic_in_q;
  assign set_pulse          = set_pulse_q;

endmodule
`default_nettype wire

// ---- hdl/ecl_host_io.sv ----
// Host end: issues set commands and the controller start sequence.
// Assumes sense inputs (controller busy, abnormal halt, receiving
// device busy) are synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module ecl_host_io
  import ecl_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  ecl_io_if.host            io,
  input  wire logic         set_req,
  input  wire logic [2:0]   set_line,
  input  wire logic         chain_mode,
  input  wire logic         bic_start,
  input  wire logic [5:0]   bic_addr,
  input  wire logic [15:0]  bic_first,
  input  wire logic [15:0]  bic_last,
  input  wire logic         bic_busy,
  input  wire logic         bic_abnormal,
  input  wire logic         dev_busy,
  output logic              req_ready,
  output logic              order_error,
  output logic              bic_done,
  output logic              bic_error
);

  // Sequencer states; CMD holds the set strobe, then returns.
  typedef enum logic [3:0] {
    ECL_IDLE, ECL_CMD, ECL_WAIT_IDLE, ECL_LOAD_FIRST,
    ECL_LOAD_LAST, ECL_ENABLE, ECL_WAIT_DEV, ECL_CONNECT, ECL_RUN
  } ecl_host_state_e;

  ecl_host_state_e st_q, st_d, ret_q, ret_d;
  logic [1:0]  cnt_q, cnt_d;       // Strobe length counter.
  logic [2:0]  line_q, line_d;     // Line of the command in flight.
  logic [5:0]  addr_q, addr_d;     // Address of the command in flight.
  logic [5:0]  bic_q, bic_d;       // Controller start address.
  logic [2:0]  next_q, next_d;     // Expected line in chained mode.
  logic        cmd_q, cmd_d;
  logic        ds_q, ds_d;
  logic [5:0]  da_q, da_d;
  logic [15:0] dd_q, dd_d;
  logic        rdy_q, rdy_d, oe_q, oe_d, dn_q, dn_d, er_q, er_d;

  // Next-state logic for the whole sequencer.
  always_comb
  begin
    st_d = st_q;  ret_d = ret_q;  cnt_d = cnt_q;
    line_d = line_q;  addr_d = addr_q;  bic_d = bic_q;
    next_d = next_q;  cmd_d = 1'b0;  ds_d = 1'b0;
    da_d = da_q;  dd_d = dd_q;  oe_d = 1'b0;
    dn_d = 1'b0;  er_d = 1'b0;  rdy_d = 1'b0;
    case (st_q)
      ECL_IDLE:
      begin
        rdy_d = 1'b1;
        if (bic_start && rdy_q)
        begin
          rdy_d = 1'b0;
          bic_d = ((bic_addr >= BIC_ADDR_MIN) &&
                   (bic_addr < BIC_ADDR_MAX) && !bic_addr[0]) ?
                  bic_addr : BIC_ADDR_START;
          st_d = ECL_WAIT_IDLE;
        end
        else if (set_req && rdy_q)
        begin
          rdy_d = 1'b0;
          if (chain_mode && (set_line != next_q))
          begin
            oe_d = 1'b1;
          end
          else
          begin
            line_d = set_line;  addr_d = DEV_ADDR;
            next_d = set_line + 3'h1;
            cmd_d = 1'b1;  cnt_d = SET_PULSE_LAST;
            ret_d = ECL_IDLE;  st_d = ECL_CMD;
          end
        end
      end
      ECL_CMD:
      begin
        if (cnt_q != 2'h0)
        begin
          cmd_d = 1'b1;  cnt_d = cnt_q - 2'h1;
        end
        else
        begin
          st_d = ret_q;
        end
      end
      ECL_WAIT_IDLE:
        if (!bic_busy)
        begin
          line_d = 3'h0;  addr_d = bic_q + 6'h01;
          cmd_d = 1'b1;  cnt_d = SET_PULSE_LAST;
          ret_d = ECL_LOAD_FIRST;  st_d = ECL_CMD;
        end
      ECL_LOAD_FIRST:
      begin
        ds_d = 1'b1;  da_d = bic_q;  dd_d = bic_first;
        st_d = ECL_LOAD_LAST;
      end
      ECL_LOAD_LAST:
      begin
        ds_d = 1'b1;  da_d = bic_q + 6'h01;  dd_d = bic_last;
        st_d = ECL_ENABLE;
      end
      ECL_ENABLE:
      begin
        line_d = 3'h0;  addr_d = bic_q;
        cmd_d = 1'b1;  cnt_d = SET_PULSE_LAST;
        ret_d = ECL_WAIT_DEV;  st_d = ECL_CMD;
      end
      ECL_WAIT_DEV:
        if (!dev_busy)
        begin
          st_d = ECL_CONNECT;
        end
      ECL_CONNECT:
      begin
        line_d = LINE_BIC_OUT;  addr_d = DEV_ADDR;
        cmd_d = 1'b1;  cnt_d = SET_PULSE_LAST;
        ret_d = ECL_RUN;  st_d = ECL_CMD;
      end
      ECL_RUN:
        if (bic_abnormal)
        begin
          er_d = 1'b1;  st_d = ECL_IDLE;
        end
        else if (!bic_busy)
        begin
          dn_d = 1'b1;  st_d = ECL_IDLE;
        end
      default:
        st_d = ECL_IDLE;
    endcase
  end

  // Register stage only.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      st_q <= ECL_IDLE;  ret_q <= ECL_IDLE;  cnt_q <= 2'h0;
      line_q <= 3'h0;  addr_q <= 6'h00;  bic_q <= BIC_ADDR_START;
      next_q <= 3'h0;  cmd_q <= 1'b0;  ds_q <= 1'b0;
      da_q <= 6'h00;  dd_q <= 16'h0000;  rdy_q <= 1'b0;
      oe_q <= 1'b0;  dn_q <= 1'b0;  er_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;  ret_q <= ret_d;  cnt_q <= cnt_d;
      line_q <= line_d;  addr_q <= addr_d;  bic_q <= bic_d;
      next_q <= next_d;  cmd_q <= cmd_d;  ds_q <= ds_d;
      da_q <= da_d;  dd_q <= dd_d;  rdy_q <= rdy_d;
      oe_q <= oe_d;  dn_q <= dn_d;  er_q <= er_d;
    end
  end

  assign io.ext_control_set_cmd = cmd_q;
  assign io.cmd_line  = line_q;
  assign io.cmd_addr  = addr_q;
  assign io.dout_stb  = ds_q;
  assign io.dout_addr = da_q;
  assign io.dout_data = dd_q;
  assign req_ready    = rdy_q;
  assign order_error  = oe_q;
  assign bic_done     = dn_q;
  assign bic_error    = er_q;

endmodule
`default_nettype wire

// ---- verification/ecl_assertions.sv ----
// Checker for the I/O bus between the two ends and the reset wiring.
// Assumes one clock; instantiated in the bench beside the interface.
`timescale 1ns/100ps
`default_nettype none
module ecl_checker
  import ecl_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       ext_control_set_cmd,
  input wire logic [2:0] cmd_line,
  input wire logic [5:0] cmd_addr,
  input wire logic       dout_stb,
  input wire logic [5:0] dout_addr,
  input wire logic [7:0] ext_control_out,
  input wire logic [7:0] ext_control_reset_in_n
);
  // Lines set this cycle; a set beats a reset on the same line.
  logic [7:0] set_mask;

  // Decode of the set strobe, only at the converter address.
  always_comb
  begin
    set_mask = 8'h00;
    if (ext_control_set_cmd && cmd_addr == DEV_ADDR)
      set_mask = 8'h01 << cmd_line;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  set_line_a: assert property (
    1 |=> (ext_control_out & $past(set_mask)) == $past(set_mask))
    else $error("latch not set by its command");
  only_set_a: assert property (
    1 |=> (ext_control_out & ~$past(ext_control_out)
      & ~$past(set_mask)) == 8'h00)
    else $error("latch rose without a set");
  latch_hold_a: assert property (
    1 |=> ($past(ext_control_out & ext_control_reset_in_n)
      & ~ext_control_out) == 8'h00)
    else $error("latch dropped without reset");
  reset_clear_a: assert property (
    1 |=> (ext_control_out
      & $past(~ext_control_reset_in_n & ~set_mask)) == 8'h00)
    else $error("latch not cleared by reset");
  strobe_len_a: assert property (
    $rose(ext_control_set_cmd) |=> ext_control_set_cmd
      ##1 !ext_control_set_cmd)
    else $error("set strobe not two cycles");
  strobe_fields_a: assert property (
    ext_control_set_cmd && $past(ext_control_set_cmd)
      |-> $stable(cmd_line) && $stable(cmd_addr))
    else $error("command fields moved in strobe");
  addr_pair_a: assert property (
    dout_stb && !$past(dout_stb) |=> dout_stb
      && dout_addr == $past(dout_addr) + 6'h01 ##1 !dout_stb)
    else $error("address pair out of order");
  addr_range_a: assert property (
    dout_stb |-> dout_addr >= BIC_ADDR_MIN && dout_addr <= BIC_ADDR_MAX)
    else $error("controller address out of range");
  enable_after_a: assert property (
    dout_stb && $past(dout_stb) |-> ##[1:8] (ext_control_set_cmd
      && cmd_line == LINE_BIC_OUT && !cmd_addr[0]))
    else $error("enable missing after addresses");
endmodule
`default_nettype wire

// ---- verification/ecl_latch_bank_bench.sv ----
// Bench joining the host end and the latch bank over the I/O bus.
// Assumes the reset wiring of the latches is chosen per scenario.
`timescale 1ns/100ps
`default_nettype none
module ecl_latch_bank_bench;
  import ecl_pkg::*;
  logic       core_clk, rstn, set_req, chain_mode, bic_start;
  logic       bic_busy, bic_abnormal, dev_busy;
  logic       req_ready, order_error, bic_done, bic_error;
  logic       bic_out_connect, bic_in_select;
  logic [2:0] set_line;
  logic [7:0] backplane_out, rin, rst_in_n;
  logic [1:0] wiring_mode;  // 0 external, 1 chained, 2 grounded.
  logic [5:0] bic_addr_in;  // Controller address offered to the host.
  logic [7:0] set_pulse_w;  // Registered set strobe record per line.
  int         error_cnt, n_tests;

  ecl_io_if io_if ();
  // Chained wiring: setting line k clears line k-1, wrapping at 7.
  assign rst_in_n = wiring_mode == 2'h0 ? rin : wiring_mode == 2'h1 ?
    ~{io_if.ext_control_out[0], io_if.ext_control_out[7:1]} : 8'h00;

  ecl_latch_bank ecl_latch_bank_i (.core_clk(core_clk), .rstn(rstn),
    .io(io_if), .ext_control_reset_in_n(rst_in_n),
    .backplane_out(backplane_out), .bic_out_connect(bic_out_connect),
    .bic_in_select(bic_in_select), .set_pulse(set_pulse_w));
  ecl_host_io ecl_host_io_i (.core_clk(core_clk), .rstn(rstn), .io(io_if),
    .set_req(set_req), .set_line(set_line), .chain_mode(chain_mode),
    .bic_start(bic_start), .bic_addr(bic_addr_in), .bic_first(16'h0100),
    .bic_last(16'h01ff), .bic_busy(bic_busy), .bic_abnormal(bic_abnormal),
    .dev_busy(dev_busy), .req_ready(req_ready), .order_error(order_error),
    .bic_done(bic_done), .bic_error(bic_error));
  ecl_checker ecl_checker_i (.core_clk(core_clk), .rstn(rstn),
    .ext_control_set_cmd(io_if.ext_control_set_cmd),
    .cmd_line(io_if.cmd_line), .cmd_addr(io_if.cmd_addr),
    .dout_stb(io_if.dout_stb), .dout_addr(io_if.dout_addr),
    .ext_control_out(io_if.ext_control_out),
    .ext_control_reset_in_n(rst_in_n));

  // Inputs change 10 ns after the edge so no race with the design.
  task automatic tick;
    @(posedge core_clk);
    #10;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h not %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait, since a stuck host must not hang the run.
  task automatic wait_ready;
    for (int n = 0; n < 20 && req_ready !== 1'b1; n++)
      tick;
  endtask

  task automatic do_set(input logic [2:0] line);
    wait_ready;
    set_req = 1'b1;
    set_line = line;
    tick;
    set_req = 1'b0;
    tick;
    wait_ready;
  endtask

  // All eight lines set in turn, then external reset of line 0, then of all lines.
  task automatic set_all;
    logic [7:0] exp;
    exp = 8'h00;
    wiring_mode = 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      do_set(3'(i));
      exp[i] = 1'b1;
      check(io_if.ext_control_out, exp);
      check(backplane_out, exp);
    end
    check({6'h00, bic_in_select, bic_out_connect}, 8'h03);
    rin = 8'hfe;
    tick;
    tick;
    check(io_if.ext_control_out, 8'hfe);
    rin = 8'h00;
    tick;
    tick;
    rin = 8'hff;
    check(io_if.ext_control_out, 8'h00);
  endtask

  // Chained order 0..7 and wrap, then a line out of order is refused.
  task automatic chain_run;
    logic seen;
    seen = 1'b0;
    wiring_mode = 2'h1;
    chain_mode = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      do_set(3'(i % 8));
      check(io_if.ext_control_out, 8'h01 << (i % 8));
    end
    wait_ready;
    set_req = 1'b1;
    set_line = 3'h5;
    tick;
    set_req = 1'b0;
    for (int n = 0; n < 4; n++)
    begin
      seen |= order_error;
      tick;
    end
    check({7'h00, seen}, 8'h01);
    check(io_if.ext_control_out, 8'h01);
    chain_mode = 1'b0;
  endtask

  // Grounded reset: the latch follows the two-cycle set strobe.
  task automatic pulse_run;
    int hi;
    int hp;
    hi = 0;
    hp = 0;
    wiring_mode = 2'h2;
    wait_ready;
    set_req = 1'b1;
    set_line = 3'h3;
    tick;
    set_req = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      tick;
      hi += int'(io_if.ext_control_out[3]);
      hp += int'(set_pulse_w[3]);
    end
    check(8'(hi), 8'(SET_PULSE_CYCLES));
    check(8'(hp), 8'(SET_PULSE_CYCLES));
  endtask

  // Controller start, held off by busy, ending in done or error.
  // A bad controller address must fall back to the first pair.
  task automatic bic_run(input logic abn, input logic [5:0] addr,
                         input logic [5:0] base);
    logic seen;
    int   words;
    seen = 1'b0;
    words = 0;
    bic_addr_in = addr;
    wiring_mode = 2'h0;
    rin = 8'h00;
    tick;
    rin = 8'hff;
    bic_busy = 1'b1;
    dev_busy = 1'b1;
    wait_ready;
    bic_start = 1'b1;
    tick;
    bic_start = 1'b0;
    for (int n = 0; n < 6; n++)
    begin
      tick;
      seen |= io_if.ext_control_set_cmd;
    end
    check({7'h00, seen}, 8'h00);
    bic_busy = 1'b0;
    for (int n = 0; n < 20 && io_if.ext_control_set_cmd !== 1'b1; n++)
      tick;
    check(8'(io_if.cmd_addr), {2'h0, base + 6'h01});
    for (int n = 0; n < 40 && !(io_if.ext_control_set_cmd === 1'b1
         && io_if.cmd_addr === base); n++)
    begin
      // Each address word stands one cycle; look at it while it stands.
      if (io_if.dout_stb === 1'b1)
      begin
        check(8'(io_if.dout_addr), {2'h0, base} + 8'(words));
        check(io_if.dout_data[7:0], words == 0 ? 8'h00 : 8'hff);
        check(io_if.dout_data[15:8], 8'h01);
        words++;
      end
      tick;
    end
    check(8'(words), 8'h02);
    bic_busy = 1'b1;
    repeat (6) tick;
    check(io_if.ext_control_out, 8'h00);
    dev_busy = 1'b0;
    for (int n = 0; n < 20 && bic_out_connect !== 1'b1; n++)
      tick;
    check({7'h00, bic_out_connect}, 8'h01);
    if (abn)
      bic_abnormal = 1'b1;
    else
      bic_busy = 1'b0;
    seen = 1'b0;
    for (int n = 0; n < 20 && !seen; n++)
    begin
      seen = abn ? bic_error : bic_done;
      tick;
    end
    check({7'h00, seen}, 8'h01);
    bic_abnormal = 1'b0;
    bic_busy = 1'b0;
  endtask

  // Free-running 10 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // A hang past 1000000 ns, far beyond the expected run, counts as a mismatch.
  initial
  begin
    #1000000;
    error_cnt++;
    give_verdict;
  end

  initial
  begin
    rstn = 1'b0;
    {set_req, chain_mode, bic_start, bic_busy, bic_abnormal} = 5'h00;
    dev_busy = 1'b0;
    set_line = 3'h0;
    rin = 8'hff;
    wiring_mode = 2'h0;
    bic_addr_in = 6'h12;
    error_cnt = 0;
    n_tests = 0;
    repeat (20) tick;
    check(io_if.ext_control_out, LATCH_RESET);
    rstn = 1'b1;
    set_all;
    chain_run;
    pulse_run;
    bic_run(1'b0, 6'h12, 6'h12);
    bic_run(1'b1, 6'h15, BIC_ADDR_START);
    give_verdict;
  end
endmodule
`default_nettype wire
